// >>> hw/iwc_ctrl.sv
// Interrupt and wake-up controller: flags, enables, four-level priority, power modes
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/100ps
module iwc_ctrl
   import iwc_pkg::*;
#(
   parameter int N_P1 = 4
)
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire iwc_pkg::iwc_av_req_t avs_req,
   output iwc_pkg::iwc_av_rsp_t avs_rsp,
   input wire logic ext_pin_a,
   input wire logic ext_pin_b,
   input wire logic ext_pin_c,
   input wire logic [N_P1-1:0] port1_pins,
   input wire logic [5:0] periph_req,
   input wire logic timer3_evt,
   input wire logic conv_evt,
   input wire logic touch_evt,
   input wire logic cpu_ack,
   input wire logic cpu_reti,
   output iwc_pkg::iwc_irq_t cpu_irq,
   output iwc_pkg::iwc_mode_t power_mode,
   output logic halt_resume
);
   import iwc_pkg::*;

   if (N_P1 < 1 || N_P1 > 4) begin : g_bad_p1
      $error("N_P1 must lie between 1 and 4");
   end

   iwc_state_t st_q;
   iwc_state_t st_d;

   // Reserved slot is skipped so sources at its index and above shift up one slot
   function automatic logic [15:0] vec_of(input logic [3:0] src);
      logic [3:0] slot;
      slot = (src < RSVD_SLOT) ? src : src + 4'h1;
      return VEC_BASE + {9'h000, slot, 3'b000};
   endfunction : vec_of

   function automatic logic [1:0] lvl_of(input logic [3:0] src, input logic [11:0] hi,
                                         input logic [11:0] lo);
      return {hi[src], lo[src]};
   endfunction : lvl_of

   logic [2:0] pins;
   logic [2:0] fall;
   logic [2:0] pin_en;
   logic [2:0] low_en;
   logic [3:0] p1_now;
   logic [3:0] p1_chg;
   logic [11:0] req;
   logic [11:0] en;
   logic [11:0] pend;
   logic [11:0] hi_all;
   logic [11:0] lo_all;
   logic found;
   logic [3:0] best_src;
   logic [1:0] best_lvl;
   logic allowed;
   logic refuse;
   logic halt_wake;
   logic bus_wr;
   logic [7:0] wd;

   always_comb
   begin
      st_d = st_q;
      pins = {ext_pin_c, ext_pin_b, ext_pin_a};
      p1_now = 4'h0;
      p1_now[N_P1-1:0] = port1_pins;
      fall = st_q.pin_prev & ~pins;
      pin_en = {st_q.iex[BIT_PIN2_EN], st_q.iem[BIT_PIN1_EN], st_q.iem[BIT_PIN0_EN]};
      low_en = ~pins & pin_en;
      p1_chg = (p1_now ^ st_q.p1_prev) & st_q.p1wk;
      st_d.pin_prev = pins;
      st_d.p1_prev = p1_now;

      // Request lines by source index; index order equals vector order
      req = {periph_req[5], periph_req[4],
             st_q.xflg[BIT_ADC_FLAG] | st_q.xflg[BIT_TK_FLAG],
             st_q.xflg[BIT_PIN2_FLAG], st_q.xflg[BIT_PCHG_FLAG], st_q.xflg[BIT_TM3_FLAG],
             periph_req[3], periph_req[2], periph_req[1],
             st_q.timer_ext_int_control[BIT_PIN1_TYPE] ? st_q.timer_ext_int_control[BIT_PIN1_FLAG] : ~ext_pin_b,
             periph_req[0],
             st_q.timer_ext_int_control[BIT_PIN0_TYPE] ? st_q.timer_ext_int_control[BIT_PIN0_FLAG] : ~ext_pin_a};
      en = {st_q.iex[5:0], st_q.iem[5:0]};
      pend = req & en & {N_SRC{st_q.iem[BIT_GLOBAL_EN]}};
      hi_all = {st_q.phx[5:0], st_q.phm[5:0]};
      lo_all = {st_q.plx[5:0], st_q.plm[5:0]};

      // Strictly greater keeps the lowest index among equals
      found = 1'b0;
      best_src = 4'h0;
      best_lvl = 2'b00;
      for (int s = 0; s < N_SRC; s++)
      begin
         if (pend[s] && (!found || lvl_of(4'(s), hi_all, lo_all) > best_lvl))
         begin
            found = 1'b1;
            best_src = 4'(s);
            best_lvl = lvl_of(4'(s), hi_all, lo_all);
         end
      end
      allowed = found && ((st_q.in_svc >> best_lvl) == 4'h0);

      // Bus slave: one wait cycle, write lands on the edge waitrequest is low
      bus_wr = avs_req.write && !st_q.waitreq;
      wd = avs_req.writedata[7:0];
      st_d.waitreq = 1'b1;
      st_d.rdata = 32'h0000_0000;
      if ((avs_req.read || avs_req.write) && st_q.waitreq)
      begin
         st_d.waitreq = 1'b0;
         if (avs_req.read)
         begin
            unique case (avs_req.address)
               IDX_POWER_CONTROL: st_d.rdata[7:0] = st_q.power_control;
               IDX_TIMER_EXT_INT_CONTROL: st_d.rdata[7:0] = st_q.timer_ext_int_control;
               IDX_XFLG: st_d.rdata[7:0] = st_q.xflg;
               IDX_P1WK: st_d.rdata[7:0] = {4'h0, st_q.p1wk};
               IDX_IEM: st_d.rdata[7:0] = st_q.iem;
               IDX_IEX: st_d.rdata[7:0] = st_q.iex;
               IDX_PLM: st_d.rdata[7:0] = st_q.plm;
               IDX_PHM: st_d.rdata[7:0] = st_q.phm;
               IDX_PLX: st_d.rdata[7:0] = st_q.plx;
               IDX_PHX: st_d.rdata[7:0] = st_q.phx;
               default: st_d.rdata = 32'h0000_0000;
            endcase
         end
      end
      refuse = |low_en;
      if (bus_wr)
      begin
         unique case (avs_req.address)
            IDX_POWER_CONTROL: st_d.power_control = (st_q.power_control & ~POWER_CONTROL_KEEP_MASK) | (wd & POWER_CONTROL_KEEP_MASK);
            IDX_TIMER_EXT_INT_CONTROL: st_d.timer_ext_int_control = wd;
            IDX_XFLG: st_d.xflg = st_q.xflg & (wd | ~XFLG_MASK);
            IDX_P1WK: st_d.p1wk = wd[3:0];
            IDX_IEM: st_d.iem = wd & IEM_MASK;
            IDX_IEX: st_d.iex = wd & LOW6_MASK;
            IDX_PLM: st_d.plm = wd & LOW6_MASK;
            IDX_PHM: st_d.phm = wd & LOW6_MASK;
            IDX_PLX: st_d.plx = wd & LOW6_MASK;
            IDX_PHX: st_d.phx = wd & LOW6_MASK;
            default: st_d.rdata = 32'h0000_0000;
         endcase
      end

      // Handler return drops the highest level in service, so the preempted one resumes
      if (cpu_reti)
      begin
         if (st_q.in_svc[3])
            st_d.in_svc[3] = 1'b0;
         else if (st_q.in_svc[2])
            st_d.in_svc[2] = 1'b0;
         else if (st_q.in_svc[1])
            st_d.in_svc[1] = 1'b0;
         else
            st_d.in_svc[0] = 1'b0;
      end
      if (cpu_ack && st_q.irq_req)
      begin
         st_d.in_svc[st_q.irq_lvl] = 1'b1;
         unique case (st_q.irq_src)
            SRC_PIN0: st_d.timer_ext_int_control[BIT_PIN0_FLAG] = 1'b0;
            SRC_PIN1: st_d.timer_ext_int_control[BIT_PIN1_FLAG] = 1'b0;
            SRC_PCHG: st_d.xflg[BIT_PCHG_FLAG] = 1'b0;
            SRC_PIN2: st_d.xflg[BIT_PIN2_FLAG] = 1'b0;
            default: st_d.in_svc[st_q.irq_lvl] = 1'b1;
         endcase
      end

      // Sets come last so an event beats a clear in the same cycle
      st_d.timer_ext_int_control[BIT_PIN0_FLAG] = st_d.timer_ext_int_control[BIT_PIN0_FLAG] | fall[0];
      st_d.timer_ext_int_control[BIT_PIN1_FLAG] = st_d.timer_ext_int_control[BIT_PIN1_FLAG] | fall[1];
      st_d.xflg[BIT_PIN2_FLAG] = st_d.xflg[BIT_PIN2_FLAG] | fall[2];
      st_d.xflg[BIT_PCHG_FLAG] = st_d.xflg[BIT_PCHG_FLAG] | (|p1_chg);
      st_d.xflg[BIT_TM3_FLAG] = st_d.xflg[BIT_TM3_FLAG] | timer3_evt;
      st_d.xflg[BIT_ADC_FLAG] = st_d.xflg[BIT_ADC_FLAG] | conv_evt;
      st_d.xflg[BIT_TK_FLAG] = st_d.xflg[BIT_TK_FLAG] | touch_evt;

      // Power modes; pin wake ignores the global enable and the pin-change enable
      halt_wake = (|(fall & pin_en)) || (|low_en) || (|p1_chg);
      st_d.resume = 1'b0;
      unique case (st_q.mode)
         MODE_RUN:
         begin
            if (bus_wr && avs_req.address == IDX_POWER_CONTROL && wd[BIT_PD] && !refuse)
            begin
               st_d.mode = MODE_HALT;
               st_d.power_control[BIT_PD] = 1'b1;
            end
            else if (bus_wr && avs_req.address == IDX_POWER_CONTROL && wd[BIT_IDL])
            begin
               st_d.mode = MODE_IDLE;
               st_d.power_control[BIT_IDL] = 1'b1;
            end
         end
         MODE_IDLE:
         begin
            if (|pend)
            begin
               st_d.mode = MODE_RUN;
               st_d.power_control[BIT_IDL] = 1'b0;
            end
         end
         MODE_HALT:
         begin
            if (halt_wake)
            begin
               st_d.mode = MODE_RUN;
               st_d.power_control[BIT_PD] = 1'b0;
               st_d.resume = 1'b1;
            end
         end
         default:
         begin
            st_d.mode = MODE_RUN;
            st_d.power_control[BIT_PD] = 1'b0;
            st_d.power_control[BIT_IDL] = 1'b0;
         end
      endcase

      // No request while halted or while the resumed instruction runs
      st_d.irq_req = allowed && !(cpu_ack && st_q.irq_req) && st_q.mode != MODE_HALT
                     && !st_d.resume && !st_q.resume;
      st_d.irq_src = best_src;
      st_d.irq_vec = vec_of(best_src);
      st_d.irq_lvl = best_lvl;
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         st_q <= ST_RESET;
      else
         st_q <= st_d;
   end

   assign avs_rsp = '{waitrequest: st_q.waitreq, readdata: st_q.rdata};
   assign cpu_irq = '{req: st_q.irq_req, vector: st_q.irq_vec, level: st_q.irq_lvl};
   assign power_mode = st_q.mode;
   assign halt_resume = st_q.resume;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   sequence s_pd_write;
      avs_req.write && !st_q.waitreq && avs_req.address == IDX_POWER_CONTROL
         && avs_req.writedata[BIT_PD] && st_q.mode == MODE_RUN;
   endsequence

   sequence s_pin2_ack;
      cpu_ack && st_q.irq_req && st_q.irq_src == SRC_PIN2 ##0 ext_pin_c;
   endsequence

   a_halt_refused: assert property (s_pd_write ##0 refuse |=> st_q.mode != MODE_HALT)
      else $error("halt entered while an enabled pin was low");
   a_halt_entered: assert property (s_pd_write ##0 !refuse |=> st_q.mode == MODE_HALT)
      else $error("power-down write did not enter halt");
   a_pin0_edge: assert property ($past(ext_pin_a) && !ext_pin_a |=> st_q.timer_ext_int_control[BIT_PIN0_FLAG])
      else $error("pin a falling edge did not set its flag");
   a_pin2_edge_clear: assert property (s_pin2_ack ##1 ext_pin_c |-> !st_q.xflg[BIT_PIN2_FLAG])
      else $error("pin c flag not cleared on handler entry");
   a_xflg_one_keeps: assert property (avs_req.write && !st_q.waitreq
      && avs_req.address == IDX_XFLG && avs_req.writedata[BIT_TM3_FLAG]
      && st_q.xflg[BIT_TM3_FLAG] |=> st_q.xflg[BIT_TM3_FLAG])
      else $error("writing one changed a flag");
   a_global_gate: assert property (!st_q.iem[BIT_GLOBAL_EN] |=> !st_q.irq_req)
      else $error("request issued with global enable off");
   a_vec_reserved: assert property (st_q.irq_req |-> st_q.irq_vec != VEC_RSVD
      && st_q.irq_vec[2:0] == 3'b011)
      else $error("bad vector issued");
   a_nest_block: assert property (st_q.irq_req && !$past(cpu_reti) && !$past(cpu_ack)
      |-> (st_q.in_svc >> st_q.irq_lvl) == 4'h0)
      else $error("request at or below level in service");
   a_halt_resume: assert property (st_q.mode == MODE_HALT ##1 st_q.mode == MODE_RUN
      |-> halt_resume && !st_q.irq_req ##1 !st_q.irq_req)
      else $error("service started before the resumed instruction");
   a_pchg_flag: assert property (|p1_chg |=> st_q.xflg[BIT_PCHG_FLAG])
      else $error("enabled port change did not set flag");
   a_idle_wake: assert property (st_q.mode == MODE_IDLE && |pend |=> st_q.mode == MODE_RUN)
      else $error("idle not left on enabled request");
endmodule : iwc_ctrl

// >>> hw/iwc_pkg.sv
// Constants, types and register map of the interrupt and wake-up controller
package iwc_pkg;
   // Register indices; the byte address is four times the index
   localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;
   localparam logic [7:0] IDX_TIMER_EXT_INT_CONTROL = 8'h88;
   localparam logic [7:0] IDX_XFLG = 8'h95;
   localparam logic [7:0] IDX_P1WK = 8'h96;
   localparam logic [7:0] IDX_IEM = 8'hA8;
   localparam logic [7:0] IDX_IEX = 8'hA9;
   localparam logic [7:0] IDX_PLM = 8'hB8;
   localparam logic [7:0] IDX_PHM = 8'hB9;
   localparam logic [7:0] IDX_PLX = 8'hBA;
   localparam logic [7:0] IDX_PHX = 8'hBB;
   // Field positions
   localparam int BIT_GLOBAL_EN = 7;
   localparam int BIT_PD = 1;
   localparam int BIT_IDL = 0;
   localparam int BIT_PIN0_TYPE = 0;
   localparam int BIT_PIN0_FLAG = 1;
   localparam int BIT_PIN1_TYPE = 2;
   localparam int BIT_PIN1_FLAG = 3;
   localparam int BIT_TM3_FLAG = 0;
   localparam int BIT_PCHG_FLAG = 1;
   localparam int BIT_PIN2_FLAG = 2;
   localparam int BIT_ADC_FLAG = 4;
   localparam int BIT_TK_FLAG = 5;
   localparam int BIT_PIN0_EN = 0;
   localparam int BIT_PIN1_EN = 2;
   localparam int BIT_PIN2_EN = 2;
   // Writable masks and reset values
   localparam logic [7:0] POWER_CONTROL_KEEP_MASK = 8'h8C;
   localparam logic [7:0] IEM_MASK = 8'hBF;
   localparam logic [7:0] LOW6_MASK = 8'h3F;
   localparam logic [7:0] XFLG_MASK = 8'h37;
   localparam logic [7:0] REG_RESET = 8'h00;
   // Sources and vectors
   localparam int N_SRC = 12;
   localparam logic [3:0] SRC_PIN0 = 4'h0;
   localparam logic [3:0] SRC_PIN1 = 4'h2;
   localparam logic [3:0] SRC_PCHG = 4'h7;
   localparam logic [3:0] SRC_PIN2 = 4'h8;
   localparam logic [3:0] RSVD_SLOT = 4'h6;
   localparam logic [15:0] VEC_BASE = 16'h0003;
   localparam logic [15:0] VEC_RSVD = 16'h0033;

   typedef enum logic [1:0] {
      MODE_RUN = 2'b00,
      MODE_IDLE = 2'b01,
      MODE_HALT = 2'b10
   } iwc_mode_t;

   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] address;
      logic [31:0] writedata;
   } iwc_av_req_t;

   typedef struct packed {
      logic waitrequest;
      logic [31:0] readdata;
   } iwc_av_rsp_t;

   typedef struct packed {
      logic req;
      logic [15:0] vector;
      logic [1:0] level;
   } iwc_irq_t;

   typedef struct packed {
      logic [7:0] power_control;
      logic [7:0] timer_ext_int_control;
      logic [7:0] xflg;
      logic [3:0] p1wk;
      logic [7:0] iem;
      logic [7:0] iex;
      logic [7:0] plm;
      logic [7:0] phm;
      logic [7:0] plx;
      logic [7:0] phx;
      iwc_mode_t mode;
      logic [3:0] in_svc;
      logic [2:0] pin_prev;
      logic [3:0] p1_prev;
      logic irq_req;
      logic [3:0] irq_src;
      logic [15:0] irq_vec;
      logic [1:0] irq_lvl;
      logic resume;
      logic waitreq;
      logic [31:0] rdata;
   } iwc_state_t;

   localparam iwc_state_t ST_RESET = '{mode: MODE_RUN, pin_prev: 3'b111, p1_prev: 4'hF,
                                       waitreq: 1'b1, default: '0};
endpackage : iwc_pkg

// >>> bench/iwc_cpu_model.sv
// CPU-side model: takes vectored requests after a set delay and returns on command
`timescale 1ns/100ps
module iwc_cpu_model
   import iwc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire iwc_pkg::iwc_irq_t cpu_irq,
   input wire logic ack_en,
   input wire logic [3:0] ack_dly,
   input wire logic reti_go,
   output logic cpu_ack,
   output logic cpu_reti,
   output logic [15:0] last_vec_q
);
   import iwc_pkg::*;
   logic [3:0] wait_q;
   logic [3:0] depth_q;
   always_ff @(posedge ref_clk)
   begin
      cpu_ack <= 1'b0;
      cpu_reti <= 1'b0;
      if (srst)
      begin
         wait_q <= 4'h0;
         depth_q <= 4'h0;
         last_vec_q <= 16'h0000;
      end
      else
      begin
         // No second ack while the taken request is still dropping
         if (cpu_irq.req && ack_en && !cpu_ack)
         begin
            wait_q <= (wait_q >= ack_dly) ? 4'h0 : wait_q + 4'h1;
            cpu_ack <= (wait_q >= ack_dly);
         end
         else
            wait_q <= 4'h0;
         if (cpu_ack && cpu_irq.req)
         begin
            last_vec_q <= cpu_irq.vector;
            depth_q <= depth_q + 4'h1;
         end
         // Return only from a handler actually entered
         if (reti_go && depth_q != 4'h0)
         begin
            cpu_reti <= 1'b1;
            depth_q <= depth_q - 4'h1;
         end
      end
   end
endmodule : iwc_cpu_model

// >>> bench/iwc_ctrl_tb.sv
// Self-checking bench for the interrupt and wake-up controller
`timescale 1ns/100ps
module iwc_ctrl_tb;
   import iwc_pkg::*;
   logic ref_clk, srst, pin_a, pin_b, pin_c, t3_evt, cv_evt, tk_evt;
   logic cpu_ack, cpu_reti, ack_en, reti_go, resume;
   logic [3:0] p1, ack_dly;
   logic [5:0] preq;
   logic [15:0] last_vec;
   logic [31:0] rd;
   iwc_av_req_t req;
   iwc_av_rsp_t rsp;
   iwc_irq_t irq;
   iwc_mode_t mode;
   int err_total;
   int samples_checked;
   logic [7:0] idx [10] = '{8'h87, 8'h88, 8'h95, 8'h96, 8'hA8, 8'hA9, 8'hB8, 8'hB9, 8'hBA, 8'hBB};
   logic [15:0] pvec [6] = '{16'h000B, 16'h001B, 16'h0023, 16'h002B, 16'h005B, 16'h0063};

   iwc_ctrl #(.N_P1(4)) u_iwc_ctrl (.ref_clk(ref_clk), .srst(srst), .avs_req(req),
      .avs_rsp(rsp), .ext_pin_a(pin_a), .ext_pin_b(pin_b), .ext_pin_c(pin_c),
      .port1_pins(p1), .periph_req(preq), .timer3_evt(t3_evt), .conv_evt(cv_evt),
      .touch_evt(tk_evt), .cpu_ack(cpu_ack), .cpu_reti(cpu_reti), .cpu_irq(irq),
      .power_mode(mode), .halt_resume(resume));
   iwc_cpu_model u_iwc_cpu_model (.ref_clk(ref_clk), .srst(srst), .cpu_irq(irq),
      .ack_en(ack_en), .ack_dly(ack_dly), .reti_go(reti_go), .cpu_ack(cpu_ack),
      .cpu_reti(cpu_reti), .last_vec_q(last_vec));

   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic summarize();
      if (err_total == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         err_total++;
      end
   endtask : chk

   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : step

   // Request held until the edge where waitrequest is seen low
   task automatic bus(input logic is_wr, input logic [7:0] a, input logic [7:0] d);
      req.read <= !is_wr;
      req.write <= is_wr;
      req.address <= a;
      req.writedata <= {24'h000000, d};
      do
         @(posedge ref_clk);
      while (rsp.waitrequest !== 1'b0);
      rd = rsp.readdata;
      req.read <= 1'b0;
      req.write <= 1'b0;
      @(posedge ref_clk);
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      chk(rd, {24'h000000, exp});
   endtask : rdc

   // Waits for a request, checks its vector, lets the model take it
   task automatic serve(input logic [15:0] v);
      int n;
      n = 0;
      while (irq.req !== 1'b1 && n < 30)
      begin
         step(1);
         n++;
      end
      chk(32'(irq.vector), 32'(v));
      // The model may wait several cycles before it takes the request
      ack_en <= 1'b1;
      n = 0;
      while (cpu_ack !== 1'b1 && n < 30)
      begin
         step(1);
         n++;
      end
      step(1);
      ack_en <= 1'b0;
      chk(32'(last_vec), 32'(v));
   endtask : serve

   task automatic reti();
      reti_go <= 1'b1;
      step(1);
      reti_go <= 1'b0;
      step(2);
   endtask : reti

   task automatic t_regs();
      foreach (idx[i]) rdc(idx[i], 8'h00);
      rdc(8'h00, 8'h00);
      wr(8'h96, 8'hFF);
      rdc(8'h96, 8'h0F);
      wr(8'hA8, 8'hFF);
      rdc(8'hA8, 8'hBF);
      wr(8'hA8, 8'h00);
      wr(8'h96, 8'h00);
   endtask : t_regs

   task automatic t_flags();
      wr(8'h88, 8'h05);
      pin_a <= 1'b0;
      pin_b <= 1'b0;
      pin_c <= 1'b0;
      p1 <= 4'hD;
      step(3);
      rdc(8'h88, 8'h0F);
      t3_evt <= 1'b1;
      cv_evt <= 1'b1;
      tk_evt <= 1'b1;
      step(1);
      {t3_evt, cv_evt, tk_evt} <= 3'b000;
      step(2);
      rdc(8'h95, 8'h35);
      wr(8'h96, 8'h01);
      p1 <= 4'hC;
      step(3);
      rdc(8'h95, 8'h37);
      chk(32'(irq.req), 32'h0);
      wr(8'h95, 8'hFB);
      rdc(8'h95, 8'h33);
      wr(8'h95, 8'hFD);
      rdc(8'h95, 8'h31);
      wr(8'h96, 8'h00);
      {pin_a, pin_b, pin_c, p1} <= 7'h7F;
      wr(8'h95, 8'h00);
      wr(8'h88, 8'h05);
      rdc(8'h95, 8'h00);
   endtask : t_flags

   task automatic t_service();
      wr(8'hA8, 8'h85);
      pin_a <= 1'b0;
      pin_b <= 1'b0;
      serve(16'h0003);
      step(3);
      chk(32'(irq.req), 32'h0);
      rdc(8'h88, 8'h0D);
      reti();
      serve(16'h0013);
      reti();
      {pin_a, pin_b} <= 2'b11;
      wr(8'hA8, 8'hBA);
      wr(8'hA9, 8'h30);
      for (int i = 0; i < 6; i++)
      begin
         preq <= 6'(1 << i);
         serve(pvec[i]);
         preq <= 6'h00;
         reti();
      end
      wr(8'hA9, 8'h34);
      pin_c <= 1'b0;
      step(2);
      pin_c <= 1'b1;
      serve(16'h004B);
      rdc(8'h95, 8'h00);
      reti();
   endtask : t_service

   task automatic t_prio();
      wr(8'hB9, 8'h02);
      wr(8'hBA, 8'h20);
      wr(8'hBB, 8'h20);
      preq <= 6'h01;
      serve(16'h000B);
      chk(32'(irq.level), 32'h2);
      preq <= 6'h21;
      serve(16'h0063);
      chk(32'(irq.req), 32'h0);
      preq <= 6'h00;
      reti();
      reti();
      foreach (idx[i]) if (i > 3) wr(idx[i], 8'h00);
   endtask : t_prio

   task automatic t_power();
      wr(8'hA8, 8'h03);
      pin_a <= 1'b0;
      step(2);
      wr(8'h87, 8'h02);
      step(2);
      chk(32'(mode), 32'(MODE_RUN));
      pin_a <= 1'b1;
      wr(8'h88, 8'h05);
      wr(8'h87, 8'h02);
      step(2);
      chk(32'(mode), 32'(MODE_HALT));
      preq <= 6'h01;
      step(5);
      chk(32'(mode), 32'(MODE_HALT));
      pin_a <= 1'b0;
      for (int n = 0; n < 20 && resume !== 1'b1; n++) step(1);
      chk(32'(resume), 32'h1);
      chk(32'(irq.req), 32'h0);
      step(3);
      chk(32'(irq.req), 32'h0);
      chk(32'(mode), 32'(MODE_RUN));
      {pin_a, preq} <= 7'h40;
      wr(8'hA8, 8'h88);
      wr(8'h87, 8'h01);
      step(2);
      chk(32'(mode), 32'(MODE_IDLE));
      preq <= 6'h02;
      serve(16'h001B);
      chk(32'(mode), 32'(MODE_RUN));
      preq <= 6'h00;
      rdc(8'h87, 8'h00);
      reti();
   endtask : t_power

   initial
   begin
      err_total = 0;
      samples_checked = 0;
      srst = 1'b1;
      req = '0;
      {pin_a, pin_b, pin_c, p1} = 7'h7F;
      {preq, t3_evt, cv_evt, tk_evt} = '0;
      {ack_en, reti_go, ack_dly} = '0;
      step(6);
      srst <= 1'b0;
      step(1);
      t_regs();
      t_flags();
      t_service();
      ack_dly <= 4'h3;
      t_prio();
      t_power();
      summarize();
   end

   initial
   begin
      #1000000;
      err_total++;
      summarize();
   end
endmodule : iwc_ctrl_tb
